// ### pkg/mpg_pkg.sv
// constants for generator a of the motor pwm block
package mpg_pkg;
  localparam int unsigned NUM_CH = 6; // outputs 0 to 5
  localparam int unsigned AW = 8; // decoded address bits
  // byte offsets
  localparam logic [7:0] OFS_INV = 8'h00; // compare_invert_control
  localparam logic [7:0] OFS_MOD = 8'h04; // modulus_register
  localparam logic [7:0] OFS_VAL0 = 8'h08; // pulse_value_0, then +4 per channel
  localparam logic [7:0] OFS_ENA = 8'h20; // generator_a_enable_control
  localparam logic [7:0] OFS_CFG = 8'h24; // timebase, lock and override setup
  localparam logic [7:0] OFS_CNT = 8'h28; // counter_a readback
  // generator_a_enable_control bits
  localparam int unsigned B_ENA = 7;
  localparam int unsigned B_GLS = 6;
  localparam int unsigned B_RST = 2;
  localparam int unsigned B_LDOK = 1;
  // configuration bits
  localparam int unsigned B_MTG = 0;
  localparam int unsigned B_WP = 1;
  localparam int unsigned B_OVC = 8; // override enables 13:8
  localparam int unsigned B_OVV = 16; // override levels 21:16
  // reset values
  localparam logic [7:0] RST_ENA = 8'h00;
  localparam logic [15:0] RST_MOD = 16'h0000;
  localparam logic [15:0] RST_VAL = 16'h0000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : mpg_pkg

// ### rtl/mpg_gen_a.sv
// pwm generator a with ahb-lite register slave
`timescale 1ns/100ps
module mpg_gen_a #(
  parameter int unsigned NCH = mpg_pkg::NUM_CH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic global_load_okay, // device level load okay
  input wire logic commutation_event, // one-cycle pulse
  input wire logic gen_bc_enable, // outputs 2-5 enable from other generators
  output logic [NCH-1:0] pwm_out,
  output logic reload_pulse
);
  initial begin
    if (NCH != mpg_pkg::NUM_CH) $error("mpg_gen_a: channel count must be six");
  end

  // timing in brief, for whoever drives this block:
  // - the bus slave never inserts a wait state and always answers okay
  // - an address phase is taken at the edge where hsel, hready and nonseq meet
  // - a write lands at the edge that closes its data phase
  // - read data are latched at the address edge and stand through the data phase
  // - the read mux looks at next-state values of all but the counter, so a read right behind a write
  //   to the same register already returns what was written
  // - the counter is held at zero while the generator is off
  // - setting the enable forces a reload one cycle later, whatever the load okay says
  // - later reloads happen only at a wrap, and only with load permission
  // - the local load okay is consumed by a reload; software re-arms it
  // - a commutation restart zeroes the counter but does not reload the buffers
  // - outputs follow the counter with one cycle of latency through the output flops
  // limitation: only the edge aligned count is built; center alignment is absent

  // bus data-phase state
  logic wr_pend_ff, nxt_wr_pend;
  logic [7:0] wadr_ff, nxt_wadr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  // software registers
  logic [7:0] ena_ff, nxt_ena; // generator_a_enable_control
  logic [NCH-1:0] inv_ff, nxt_inv; // compare_invert_control
  logic [31:0] cfg_ff, nxt_cfg;
  logic [15:0] mod_buf_ff, nxt_mod_buf; // buffered modulus
  logic [15:0] mod_act_ff, nxt_mod_act; // active modulus
  logic [15:0] val_buf_ff [NCH];
  logic [15:0] nxt_val_buf [NCH];
  logic [15:0] val_act_ff [NCH];
  logic [15:0] nxt_val_act [NCH];
  // counter group
  logic [15:0] cnt_ff, nxt_cnt;
  logic en_prev_ff, nxt_en_prev;
  logic reload_ff, nxt_reload;
  logic [NCH-1:0] pwm_ff, nxt_pwm;

  // response flops; the slave never stalls and never errors
  logic ready_ff, resp_ff;
  logic wr_now, en, start, wrap, restart, load_ok, do_reload;

  assign wr_now = wr_pend_ff;
  assign en = ena_ff[mpg_pkg::B_ENA];
  assign start = en && !en_prev_ff; // first cycle after enable set
  // modulus 0 or 1 is illegal; it simply wraps every cycle
  // there is no center aligned mode here, so the zero modulus case of that mode
  // cannot arise; a zero modulus only wraps every cycle and nothing else breaks
  assign wrap = (cnt_ff + mpg_pkg::CNT_ONE) >= mod_act_ff;
  assign restart = commutation_event && ena_ff[mpg_pkg::B_RST];
  // source of reload permission
  assign load_ok = ena_ff[mpg_pkg::B_GLS] ? global_load_okay : ena_ff[mpg_pkg::B_LDOK];
  // reload at every cycle start when allowed, and always on enable
  assign do_reload = start || (en && wrap && load_ok);

  // bus: latch address phase, prepare read data
  // the mux reads next-state values except for the counter: without this a read placed in the data
  // phase of a write to the same register would return the stale contents
  always_comb begin
    nxt_wr_pend = 1'b0;
    nxt_wadr = wadr_ff;
    nxt_hrdata = hrdata_ff;
    if (hsel && hready && htrans == mpg_pkg::HTRANS_NONSEQ) begin
      nxt_wr_pend = hwrite;
      nxt_wadr = haddr[7:0];
      nxt_hrdata = 32'h0000_0000; // unmapped reads give zero
      case (haddr[7:0])
        mpg_pkg::OFS_INV: nxt_hrdata = {26'h0, nxt_inv};
        mpg_pkg::OFS_MOD: nxt_hrdata = {16'h0, nxt_mod_buf};
        mpg_pkg::OFS_ENA: nxt_hrdata = {24'h0, nxt_ena}; // reads always allowed
        mpg_pkg::OFS_CFG: nxt_hrdata = nxt_cfg;
        mpg_pkg::OFS_CNT: nxt_hrdata = {16'h0, cnt_ff}; // counter value at the address edge
        default: begin
          // value registers sit four bytes apart
          for (int i = 0; i < NCH; i++) begin
            if (haddr[7:0] == mpg_pkg::OFS_VAL0 + 8'(4 * i)) nxt_hrdata = {16'h0, nxt_val_buf[i]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_ff <= 1'b0;
      wadr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b1; // ready even during reset
      resp_ff <= 1'b0;
    end else begin
      ready_ff <= 1'b1; // zero wait states
      resp_ff <= 1'b0; // okay only
      wr_pend_ff <= nxt_wr_pend;
      wadr_ff <= nxt_wadr;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // registers: writes in the data phase, buffers copied on reload
  always_comb begin
    nxt_ena = ena_ff;
    nxt_inv = inv_ff;
    nxt_cfg = cfg_ff;
    nxt_mod_buf = mod_buf_ff;
    nxt_mod_act = mod_act_ff;
    nxt_val_buf = val_buf_ff;
    nxt_val_act = val_act_ff;
    // reload consumes the local okay; a same-cycle write re-arms it below
    if (do_reload) begin
      nxt_mod_act = mod_buf_ff;
      nxt_val_act = val_buf_ff;
      nxt_ena[mpg_pkg::B_LDOK] = 1'b0;
    end
    if (wr_now) begin
      case (wadr_ff)
        mpg_pkg::OFS_INV: nxt_inv = hwdata[NCH-1:0]; // not buffered, acts at once
        mpg_pkg::OFS_MOD: nxt_mod_buf = hwdata[15:0];
        mpg_pkg::OFS_ENA: begin
          nxt_ena[mpg_pkg::B_ENA] = hwdata[mpg_pkg::B_ENA];
          nxt_ena[mpg_pkg::B_LDOK] = hwdata[mpg_pkg::B_LDOK] | nxt_ena[mpg_pkg::B_LDOK];
          if (!cfg_ff[mpg_pkg::B_WP]) begin // locked bits ignore writes
            nxt_ena[mpg_pkg::B_GLS] = hwdata[mpg_pkg::B_GLS];
            nxt_ena[mpg_pkg::B_RST] = hwdata[mpg_pkg::B_RST];
          end
        end
        mpg_pkg::OFS_CFG: begin
          nxt_cfg = hwdata & 32'h003f_3f03;
          nxt_cfg[mpg_pkg::B_WP] = hwdata[mpg_pkg::B_WP] | cfg_ff[mpg_pkg::B_WP]; // lock is sticky
        end
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (wadr_ff == mpg_pkg::OFS_VAL0 + 8'(4 * i)) nxt_val_buf[i] = hwdata[15:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ena_ff <= mpg_pkg::RST_ENA;
      inv_ff <= '0;
      cfg_ff <= 32'h0000_0000;
      mod_buf_ff <= mpg_pkg::RST_MOD;
      mod_act_ff <= mpg_pkg::RST_MOD;
      for (int i = 0; i < NCH; i++) begin
        val_buf_ff[i] <= mpg_pkg::RST_VAL;
        val_act_ff[i] <= mpg_pkg::RST_VAL;
      end
    end else begin
      ena_ff <= nxt_ena;
      inv_ff <= nxt_inv;
      cfg_ff <= nxt_cfg;
      mod_buf_ff <= nxt_mod_buf;
      mod_act_ff <= nxt_mod_act;
      val_buf_ff <= nxt_val_buf;
      val_act_ff <= nxt_val_act;
    end
  end

  // edge aligned up counter, one core clock per step
  always_comb begin
    nxt_en_prev = en;
    nxt_reload = do_reload;
    nxt_cnt = cnt_ff + mpg_pkg::CNT_ONE;
    if (!en || start || restart || wrap) nxt_cnt = mpg_pkg::CNT_ZERO;
  end

  // per channel compare; value taken as signed width in clocks
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic sval_le0, ge_mod, below, ch_en;
    logic raw_lvl; // compare result before enable and override
    logic pwm_lvl; // level the output flop takes next
    assign sval_le0 = $signed(val_act_ff[g]) <= $signed(16'sh0000);
    assign ge_mod = $signed(val_act_ff[g]) >= $signed(mod_act_ff);
    assign below = $signed(cnt_ff) < $signed(val_act_ff[g]);
    // single timebase: enable covers all; multiple: only 0 and 1
    assign ch_en = (g < 2 || !cfg_ff[mpg_pkg::B_MTG]) ? en : gen_bc_enable;
    // saturation checks come first, so a value at or below zero beats the full level and the compare; only the override below beats it
    always_comb begin
      if (sval_le0) raw_lvl = 1'b0;
      else if (ge_mod) raw_lvl = !inv_ff[g];
      else raw_lvl = inv_ff[g] ? !below : below;
      // override wins, otherwise inactive while disabled
      if (cfg_ff[mpg_pkg::B_OVC + g]) pwm_lvl = cfg_ff[mpg_pkg::B_OVV + g];
      else pwm_lvl = ch_en && raw_lvl;
    end
    // one bit per channel, so each slice keeps a single driver
    assign nxt_pwm[g] = pwm_lvl;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= mpg_pkg::CNT_ZERO;
      en_prev_ff <= 1'b0;
      reload_ff <= 1'b0;
      pwm_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      en_prev_ff <= nxt_en_prev;
      reload_ff <= nxt_reload;
      pwm_ff <= nxt_pwm;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = ready_ff; // zero wait states, from a flop
  assign hresp = resp_ff;
  assign pwm_out = pwm_ff;
  assign reload_pulse = reload_ff;

  // checks next to the logic
  a_enable_reload: assert property (@(posedge sys_clk) disable iff (!rst_b)
    start |=> reload_pulse && cnt_ff == mpg_pkg::CNT_ZERO) else $error("no reload after enable");
  a_wrap_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    en && wrap |=> cnt_ff == mpg_pkg::CNT_ZERO) else $error("counter did not wrap");
  a_count_up: assert property (@(posedge sys_clk) disable iff (!rst_b)
    en && !wrap && !restart && !start |=> cnt_ff == $past(cnt_ff) + mpg_pkg::CNT_ONE)
    else $error("counter did not step");
  a_restart_comm: assert property (@(posedge sys_clk) disable iff (!rst_b)
    restart |=> cnt_ff == mpg_pkg::CNT_ZERO) else $error("restart missed");
  a_lock_gls: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg_ff[mpg_pkg::B_WP] |=> ena_ff[mpg_pkg::B_GLS] == $past(ena_ff[mpg_pkg::B_GLS]) &&
    ena_ff[mpg_pkg::B_RST] == $past(ena_ff[mpg_pkg::B_RST])) else $error("locked bit changed");
  a_zero_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $signed(val_act_ff[0]) <= 0 && !cfg_ff[mpg_pkg::B_OVC] |=> !pwm_out[0]) else $error("output on at zero");
  a_full_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
    en && $signed(val_act_ff[0]) > 0 && $signed(val_act_ff[0]) >= $signed(mod_act_ff) &&
    !cfg_ff[mpg_pkg::B_OVC] |=> pwm_out[0] == !$past(inv_ff[0])) else $error("full level wrong");
  a_sense_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
    en && !cfg_ff[mpg_pkg::B_OVC] && $signed(val_act_ff[0]) > 0 && $signed(val_act_ff[0]) < $signed(mod_act_ff)
    |=> pwm_out[0] == ($past(inv_ff[0]) ^ ($signed($past(cnt_ff)) < $signed($past(val_act_ff[0])))))
    else $error("polarity sense wrong");
  a_disabled_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !en && !cfg_ff[mpg_pkg::B_OVC + 1] |=> !pwm_out[1]) else $error("disabled output active");
  a_mtg_split: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg_ff[mpg_pkg::B_MTG] && !gen_bc_enable && !cfg_ff[mpg_pkg::B_OVC + 2] |=> !pwm_out[2])
    else $error("timebase split ignored");
  a_global_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
    en && wrap && !start && ena_ff[mpg_pkg::B_GLS] && !global_load_okay |=> !reload_pulse)
    else $error("reload without global okay");
  a_inv_now: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_now && wadr_ff == mpg_pkg::OFS_INV |=> inv_ff == $past(hwdata[NCH-1:0]))
    else $error("polarity not taken at once");
  a_read_fwd: assert property (@(posedge sys_clk) disable iff (!rst_b)
    hsel && hready && htrans == mpg_pkg::HTRANS_NONSEQ && !hwrite && haddr[7:0] == mpg_pkg::OFS_ENA
    |=> hrdata == {24'h0, ena_ff}) else $error("enable read mismatch");
  a_bus_okay: assert property (@(posedge sys_clk) disable iff (!rst_b)
    hreadyout && !hresp) else $error("bus stalled or erred");
  c_reload: cover property (@(posedge sys_clk) disable iff (!rst_b) en && wrap && load_ok);
  c_restart: cover property (@(posedge sys_clk) disable iff (!rst_b) restart && cnt_ff != mpg_pkg::CNT_ZERO);
  c_inverted: cover property (@(posedge sys_clk) disable iff (!rst_b) inv_ff[0] && pwm_out[0]);
  c_locked_write: cover property (@(posedge sys_clk) disable iff (!rst_b)
    wr_now && wadr_ff == mpg_pkg::OFS_ENA && cfg_ff[mpg_pkg::B_WP]);
endmodule : mpg_gen_a

// ### testbench/mpg_gate_model.sv
// gate pre-driver model that tallies active cycles of output 0
`timescale 1ns/100ps
module mpg_gate_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [5:0] pwm_out,
  input wire logic win,
  output logic [15:0] high_cnt
);
  logic win_ff; // window level seen at the previous edge
  logic [15:0] nxt_high_cnt; // next tally
  // a fresh tally starts when a window opens; it is held once closed so it can be read later
  always_comb begin
    nxt_high_cnt = high_cnt;
    if (win && !win_ff) begin
      nxt_high_cnt = {15'h0, pwm_out[0]};
    end else if (win) begin
      nxt_high_cnt = high_cnt + {15'h0, pwm_out[0]};
    end
  end
  // register the tally and the window edge detector
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      high_cnt <= 16'h0000;
      win_ff <= 1'b0;
    end else begin
      high_cnt <= nxt_high_cnt;
      win_ff <= win;
    end
  end
endmodule : mpg_gate_model

// ### testbench/motor_pwm_generator_a_control_tb.sv
// self-checking bench for pwm generator a
`timescale 1ns/100ps
module motor_pwm_generator_a_control_tb;
  logic sys_clk, rst_b, hsel, hwrite, hreadyout, hresp, glo, comm, gbc, reload_pulse, win;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] pwm_out;
  logic [15:0] high_cnt;
  int fail_count = 0; // mismatches seen
  int checks = 0; // comparisons made
  mpg_gen_a i_mpg_gen_a (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .global_load_okay(glo), .commutation_event(comm),
    .gen_bc_enable(gbc), .pwm_out(pwm_out), .reload_pulse(reload_pulse));
  mpg_gate_model i_mpg_gate_model (.sys_clk(sys_clk), .rst_b(rst_b), .pwm_out(pwm_out), .win(win),
    .high_cnt(high_cnt));
  // free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // one comparison; an unknown never matches
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // single ahb-lite transfer; waits on hready under a bound instead of assuming zero wait
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    htrans <= mpg_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) fail_count++;
  endtask : bus
  // write helper that drops the read data
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  // expected active cycles of one period from modulus, value and polarity
  function logic [31:0] exp_hi(input int m, input int v, input bit p);
    if (v <= 0) return 32'h0;
    if (v >= m) return p ? 32'h0 : m;
    return p ? m - v : v;
  endfunction : exp_hi
  // end of run: counts, then the verdict
  task print_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // watchdog well beyond the expected run of about two thousand cycles
  initial begin
    #300000;
    fail_count++;
    print_verdict();
  end
  // main sequence
  initial begin
    logic [31:0] rd;
    int m, v, n;
    bit p;
    rst_b = 1'b0; hsel = 1'b1; hsize = 3'h2; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
    htrans = 2'h0; glo = 1'b0; comm = 1'b0; gbc = 1'b0; win = 1'b0;
    rd = $urandom(32'h68a8);
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, mpg_pkg::OFS_ENA, 32'h0, rd);
    check("enable reset", rd, {24'h0, mpg_pkg::RST_ENA});
    check("bus okay", {30'h0, hreadyout, hresp}, 32'h2);
    bus(1'b0, mpg_pkg::OFS_MOD, 32'h0, rd);
    check("modulus reset", rd, {16'h0, mpg_pkg::RST_MOD});
    bus(1'b0, 8'h3c, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    // corner values first, then random ones; modulus kept at two or more
    for (int i = 0; i < 30; i++) begin
      m = (i < 4) ? 8 : 2 + int'($urandom % 19);
      v = (i == 0) ? 0 : (i == 1) ? 8 : (i == 2) ? -1 : (i == 3) ? 7 : int'($urandom % (m + 7)) - 3;
      p = $urandom % 2;
      glo <= $urandom % 2;
      gbc <= $urandom % 2;
      wr(mpg_pkg::OFS_ENA, 32'h0);
      repeat (3) @(posedge sys_clk);
      check("outputs off", {26'h0, pwm_out}, 32'h0);
      wr(mpg_pkg::OFS_MOD, m);
      wr(mpg_pkg::OFS_VAL0, {16'h0, v[15:0]});
      wr(mpg_pkg::OFS_INV, {31'h0, p});
      wr(mpg_pkg::OFS_ENA, 32'h82);
      n = 0;
      while (reload_pulse !== 1'b1 && n < 6) begin @(posedge sys_clk); n++; end
      check("reload after enable", {31'h0, n < 6}, 32'h1);
      repeat (2 * m + 4) @(posedge sys_clk);
      win <= 1'b1;
      repeat (m) @(posedge sys_clk);
      win <= 1'b0;
      @(posedge sys_clk);
      check("active cycles", {16'h0, high_cnt}, exp_hi(m, v, p));
      bus(1'b0, mpg_pkg::OFS_CNT, 32'h0, rd);
      check("counter range", {31'h0, rd < m}, 32'h1);
    end
    // commutation pulse mid-period, with and without restart
    for (int k = 0; k < 2; k++) begin
      wr(mpg_pkg::OFS_MOD, 32'd20);
      wr(mpg_pkg::OFS_ENA, 32'h0);
      wr(mpg_pkg::OFS_ENA, k ? 32'h86 : 32'h82);
      repeat (10) @(posedge sys_clk);
      comm <= 1'b1;
      @(posedge sys_clk);
      comm <= 1'b0;
      bus(1'b0, mpg_pkg::OFS_CNT, 32'h0, rd);
      check("restart", {31'h0, rd < 5}, k);
    end
    // channel 2 held full on, first single then multiple timebase
    wr(mpg_pkg::OFS_INV, 32'h0);
    wr(mpg_pkg::OFS_VAL0 + 8'h08, 32'h7fff);
    wr(mpg_pkg::OFS_ENA, 32'h0);
    wr(mpg_pkg::OFS_ENA, 32'h82);
    repeat (4) @(posedge sys_clk);
    check("output 2 single", {31'h0, pwm_out[2]}, 32'h1);
    gbc <= 1'b0;
    wr(mpg_pkg::OFS_CFG, 32'h1);
    repeat (4) @(posedge sys_clk);
    check("output 2 multi", {31'h0, pwm_out[2]}, 32'h0);
    // protected bits before and after the lock; global okay low so wraps hold off reload
    glo <= 1'b0;
    wr(mpg_pkg::OFS_ENA, 32'hc4);
    bus(1'b0, mpg_pkg::OFS_ENA, 32'h0, rd);
    check("open bits", rd & 32'hc4, 32'hc4);
    wr(mpg_pkg::OFS_CFG, 32'h3);
    wr(mpg_pkg::OFS_ENA, 32'h0);
    bus(1'b0, mpg_pkg::OFS_ENA, 32'h0, rd);
    check("locked bits", rd & 32'hc4, 32'h44);
    print_verdict();
  end
endmodule : motor_pwm_generator_a_control_tb
